// [led_driver_state_config.sv]
/*
 * State configuration logic of a 16-channel LED sink driver: serial shift
 * register on the shift clock, command recognition by pulse count inside a
 * latch strobe window, the state setting registers and their decoded
 * controls, standby, grayscale clock loss watchdog and PWM commit control.
 * Assumes the host changes serialIn and latchStrobe away from the rising
 * shift clock edge and keeps the shift clock still for at least four system
 * clocks after latchStrobe falls, so the pulse count and word are stable
 * when the system side samples them.
 */
`timescale 1ns/100ps
`default_nettype none

module led_driver_state_config #(
    parameter logic [23:0] GRAY_LOSS_CYCLES = 24'(led_cfg_pkg::GRAY_LOSS_CYCLES)
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        shiftClock,
    input  wire logic        serialIn,
    input  wire logic        latchStrobe,
    input  wire logic        grayscaleClock,
    input  wire logic        pwmPeriodDone,
    output logic             serialOut,
    output logic             thermalProtectEn,
    output logic             clockLossDetectEn,
    output logic             openDetectEn,
    output logic             shortDetectEn,
    output logic             asyncMode,
    output logic             dividedPwm,
    output logic             standby2Active,
    output logic             shortLevelSecond,
    output logic             outputDelayEn,
    output logic             serialOutFalling,
    output logic             oneShotMode,
    output logic [1:0]       pwmResolution,
    output logic [16:0]      pwmMaxCount,
    output logic             internalInit,
    output logic             analogPowerDown,
    output logic             outputsReady,
    output logic             outputsForcedOff,
    output logic             pwmRun,
    output logic             pwmRestart,
    output logic             pwmLoadNow
);

    // ---------------- shift clock domain ----------------
    logic [15:0] shiftWord_reg;
    logic [4:0]  pulseCount_reg;
    logic        fallOut_reg;
    logic [2:0]  edgeSync_reg;
    logic        edgeSel_reg;

    always_ff @(posedge shiftClock or negedge resetn) begin
        if (!resetn) begin
            shiftWord_reg <= 16'h0000;
        end else begin
            shiftWord_reg <= {shiftWord_reg[14:0], serialIn};
        end
    end

    // running count of edges with the strobe high; the shift clock is still
    // while the strobe falls, so a frame with the strobe high from its first
    // edge is told apart by the system side taking the difference instead
    always_ff @(posedge shiftClock or negedge resetn) begin
        if (!resetn) begin
            pulseCount_reg <= 5'h00;
        end else if (latchStrobe) begin
            pulseCount_reg <= pulseCount_reg + 5'h01;
        end
    end

    // edge select crosses in on the shift clock; takes four edges to settle
    always_ff @(posedge shiftClock or negedge resetn) begin
        if (!resetn) begin
            edgeSync_reg <= 3'h0;
            edgeSel_reg  <= 1'b0;
        end else begin
            edgeSync_reg <= {edgeSync_reg[1:0], serialOutFalling};
            if (edgeSync_reg[1] == edgeSync_reg[2]) begin
                edgeSel_reg <= edgeSync_reg[2];
            end
        end
    end

    always_ff @(negedge shiftClock or negedge resetn) begin
        if (!resetn) begin
            fallOut_reg <= 1'b0;
        end else begin
            fallOut_reg <= shiftWord_reg[15];
        end
    end

    assign serialOut = edgeSel_reg ? fallOut_reg : shiftWord_reg[15];

    // ---------------- system clock domain ----------------
    // bit 0 latch strobe, bit 1 grayscale clock
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic [1:0] sync3_reg;
    logic       latchLevel_reg;
    logic       grayLevel_reg;
    logic       latchFall;
    logic       grayToggle;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
            sync3_reg <= 2'h0;
        end else begin
            sync1_reg <= {grayscaleClock, latchStrobe};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign latchFall  = (sync2_reg[0] == sync3_reg[0]) && !sync3_reg[0] && latchLevel_reg;
    assign grayToggle = (sync2_reg[1] == sync3_reg[1]) && (sync3_reg[1] != grayLevel_reg);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            latchLevel_reg <= 1'b0;
            grayLevel_reg  <= 1'b0;
        end else begin
            if (sync2_reg[0] == sync3_reg[0]) begin
                latchLevel_reg <= sync3_reg[0];
            end
            if (sync2_reg[1] == sync3_reg[1]) begin
                grayLevel_reg <= sync3_reg[1];
            end
        end
    end

    // count and word are quasi-static here: the strobe fall is the request
    logic [4:0] lastCount_reg;
    logic [4:0] framePulses;
    logic       cmdSecond;
    logic       cmdFirst;
    logic       cmdShift;
    logic       cmdCommit;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lastCount_reg <= 5'h00;
        end else if (latchFall) begin
            lastCount_reg <= pulseCount_reg;
        end
    end

    // frames of 32 pulses or more alias onto shorter ones
    assign framePulses = pulseCount_reg - lastCount_reg;

    assign cmdSecond = latchFall && (framePulses == led_cfg_pkg::SECOND_LOAD_PULSES_MIN
                                  || framePulses == led_cfg_pkg::SECOND_LOAD_PULSES_MAX);
    assign cmdFirst  = latchFall && framePulses == led_cfg_pkg::FIRST_LOAD_PULSES;
    assign cmdShift  = latchFall && framePulses == led_cfg_pkg::SHIFT_CMD_PULSES;
    assign cmdCommit = latchFall && framePulses == led_cfg_pkg::COMMIT_CMD_PULSES;

    logic [15:0] stateTwo_reg;
    logic [1:0]  resolution_reg;
    logic        initPulse_reg;
    logic        standby1_reg;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            stateTwo_reg <= led_cfg_pkg::STATE_WORD_TWO_RESET;
        end else if (initPulse_reg) begin
            stateTwo_reg <= led_cfg_pkg::STATE_WORD_TWO_RESET;
        end else if (cmdSecond) begin
            stateTwo_reg <= shiftWord_reg;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            resolution_reg <= led_cfg_pkg::RES_16BIT;
            initPulse_reg  <= 1'b0;
            standby1_reg   <= 1'b0;
        end else begin
            initPulse_reg <= 1'b0;
            if (cmdFirst && shiftWord_reg[led_cfg_pkg::INIT_BIT]) begin
                resolution_reg <= led_cfg_pkg::RES_16BIT;
                standby1_reg   <= 1'b0;
                initPulse_reg  <= 1'b1;
            end else if (cmdFirst) begin
                resolution_reg <= shiftWord_reg[led_cfg_pkg::RESOLUTION_MSB:
                                                led_cfg_pkg::RESOLUTION_LSB];
                standby1_reg   <= shiftWord_reg[led_cfg_pkg::STANDBY1_BIT];
            end else if (cmdShift) begin
                standby1_reg <= 1'b0;
            end
        end
    end

    // ---- decoded controls ----
    always_comb begin
        thermalProtectEn  = !stateTwo_reg[led_cfg_pkg::THERMAL_DISABLE_BIT];
        clockLossDetectEn = !stateTwo_reg[led_cfg_pkg::CLOCKLOSS_DISABLE_BIT];
        openDetectEn      = stateTwo_reg[led_cfg_pkg::OPEN_DETECT_EN_BIT];
        shortDetectEn     = stateTwo_reg[led_cfg_pkg::SHORT_DETECT_EN_BIT];
        asyncMode         = stateTwo_reg[led_cfg_pkg::ASYNC_BIT];
        dividedPwm        = stateTwo_reg[led_cfg_pkg::DIVIDED_PWM_BIT];
        standby2Active    = stateTwo_reg[led_cfg_pkg::STANDBY2_BIT]
                            && resolution_reg == led_cfg_pkg::RES_16BIT;
        shortLevelSecond  = stateTwo_reg[led_cfg_pkg::SHORT_LEVEL_BIT];
        outputDelayEn     = !stateTwo_reg[led_cfg_pkg::DELAY_DISABLE_BIT];
        serialOutFalling  = stateTwo_reg[led_cfg_pkg::SERIAL_OUT_EDGE_BIT];
        oneShotMode       = stateTwo_reg[led_cfg_pkg::ONESHOT_BIT];
        pwmResolution     = resolution_reg;
        internalInit      = initPulse_reg;
        analogPowerDown   = standby1_reg;
    end

    always_comb begin
        unique case (resolution_reg)
            led_cfg_pkg::RES_16BIT: pwmMaxCount = led_cfg_pkg::STEPS_16BIT;
            led_cfg_pkg::RES_14BIT: pwmMaxCount = led_cfg_pkg::STEPS_14BIT;
            led_cfg_pkg::RES_12BIT: pwmMaxCount = led_cfg_pkg::STEPS_12BIT;
            led_cfg_pkg::RES_10BIT: pwmMaxCount = led_cfg_pkg::STEPS_10BIT;
        endcase
    end

    // ---- standby-1 recovery ----
    logic [8:0] recovery_reg;
    logic       ready_reg;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            recovery_reg <= 9'h000;
            ready_reg    <= 1'b1;
        end else begin
            if (standby1_reg && cmdShift) begin
                recovery_reg <= 9'(led_cfg_pkg::RECOVERY_CYCLES);
            end else if (recovery_reg != 9'h000) begin
                recovery_reg <= recovery_reg - 9'h001;
            end
            ready_reg <= !standby1_reg && recovery_reg == 9'h000 && !(standby1_reg && cmdShift);
        end
    end

    assign outputsReady = ready_reg;

    // ---- grayscale clock loss watchdog ----
    // aliases at grayscale rates above a quarter of the system clock; loss still seen
    logic [23:0] lossTimer_reg;
    logic        graySeen_reg;
    logic        forcedOff_reg;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lossTimer_reg <= 24'h00_0000;
            graySeen_reg  <= 1'b0;
            forcedOff_reg <= 1'b0;
        end else begin
            // set wins: a toggle in the init cycle still counts as activity
            if (grayToggle) begin
                graySeen_reg <= 1'b1;
            end else if (initPulse_reg) begin
                graySeen_reg <= 1'b0;
            end
            if (initPulse_reg || grayToggle || !clockLossDetectEn) begin
                lossTimer_reg <= 24'h00_0000;
            end else if (graySeen_reg && lossTimer_reg != GRAY_LOSS_CYCLES) begin
                lossTimer_reg <= lossTimer_reg + 24'h00_0001;
            end
            if (initPulse_reg || grayToggle || !clockLossDetectEn) begin
                forcedOff_reg <= 1'b0;
            end else if (graySeen_reg && lossTimer_reg == GRAY_LOSS_CYCLES) begin
                forcedOff_reg <= 1'b1;
            end
        end
    end

    assign outputsForcedOff = forcedOff_reg;

    // ---- PWM commit control ----
    logic runPwm_reg;
    logic pending_reg;
    logic restart_reg;
    logic loadNow_reg;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            runPwm_reg  <= 1'b0;
            pending_reg <= 1'b0;
            restart_reg <= 1'b0;
            loadNow_reg <= 1'b0;
        end else begin
            restart_reg <= 1'b0;
            loadNow_reg <= 1'b0;
            if (initPulse_reg) begin
                runPwm_reg  <= 1'b0;
                pending_reg <= 1'b0;
            end else if (cmdCommit && (asyncMode || !runPwm_reg)) begin
                restart_reg <= 1'b1;
                runPwm_reg  <= 1'b1;
                pending_reg <= 1'b0;
            end else if (cmdCommit) begin
                pending_reg <= 1'b1;
            end else if (pwmPeriodDone && runPwm_reg && pending_reg) begin
                loadNow_reg <= 1'b1;
                pending_reg <= 1'b0;
            end else if (pwmPeriodDone && runPwm_reg && oneShotMode) begin
                runPwm_reg <= 1'b0;
            end
        end
    end

    assign pwmRun     = runPwm_reg;
    assign pwmRestart = restart_reg;
    assign pwmLoadNow = loadNow_reg;

    // ---------------- checks ----------------
    sequence s_standby_exit;
        standby1_reg && cmdShift;
    endsequence

    sequence s_recover;
        !outputsReady [*8] ##[1:300] outputsReady;
    endsequence

    a_second_load: assert property (@(posedge clock) disable iff (!resetn)
        cmdSecond && !initPulse_reg |=> stateTwo_reg == $past(shiftWord_reg))
        else $error("state word two not loaded");
    a_count_gate: assert property (@(posedge clock) disable iff (!resetn)
        (!cmdSecond && !initPulse_reg) |=> $stable(stateTwo_reg))
        else $error("state word two changed without load");
    a_thermal_map: assert property (@(posedge clock) disable iff (!resetn)
        cmdSecond && !initPulse_reg
        |=> thermalProtectEn == !$past(shiftWord_reg[led_cfg_pkg::THERMAL_DISABLE_BIT]))
        else $error("thermal enable mismatch");
    a_standby2_gate: assert property (@(posedge clock) disable iff (!resetn)
        standby2Active |-> resolution_reg == 2'h0 && stateTwo_reg[9])
        else $error("standby two outside 16-bit");
    a_init_clears: assert property (@(posedge clock) disable iff (!resetn)
        initPulse_reg |=> stateTwo_reg == 16'h0000 && !pwmRun ##1 !internalInit)
        else $error("init did not clear state");
    a_standby_exit: assert property (@(posedge clock) disable iff (!resetn)
        s_standby_exit |=> !analogPowerDown ##0 s_recover)
        else $error("standby one recovery wrong");
    a_loss_force: assert property (@(posedge clock) disable iff (!resetn)
        $rose(outputsForcedOff) |-> $past(graySeen_reg) && $past(clockLossDetectEn)
        && $past(lossTimer_reg) == GRAY_LOSS_CYCLES)
        else $error("forced off without loss");
    a_loss_release: assert property (@(posedge clock) disable iff (!resetn)
        grayToggle || initPulse_reg |=> !outputsForcedOff)
        else $error("forced off not released");
    a_async_restart: assert property (@(posedge clock) disable iff (!resetn)
        cmdCommit && asyncMode && !initPulse_reg |=> pwmRestart && pwmRun)
        else $error("async commit did not restart");
    a_sync_defer: assert property (@(posedge clock) disable iff (!resetn)
        cmdCommit && !asyncMode && pwmRun && !initPulse_reg |=> !pwmRestart && pending_reg)
        else $error("sync commit not deferred");
    a_repeat_runs: assert property (@(posedge clock) disable iff (!resetn)
        pwmRun && !oneShotMode && !initPulse_reg |=> pwmRun)
        else $error("repeat mode stopped");

endmodule

`default_nettype wire

// [led_cfg_pkg.sv]
/*
 * Constants for the LED driver state configuration block: command pulse
 * counts, state word bit positions, reset values and timing counts.
 * Assumes a 10 MHz system clock; used by the design, the bench keeps its own values.
 */
package led_cfg_pkg;
    localparam int WORD_W = 16;
    localparam int CNT_W  = 5;

    // pulse counts seen while latch_strobe is high
    localparam logic [4:0] SECOND_LOAD_PULSES_MIN = 5'h0f;
    localparam logic [4:0] SECOND_LOAD_PULSES_MAX = 5'h10;
    localparam logic [4:0] SHIFT_CMD_PULSES       = 5'h01;
    localparam logic [4:0] COMMIT_CMD_PULSES      = 5'h03;
    localparam logic [4:0] FIRST_LOAD_PULSES      = 5'h05;
    localparam logic [4:0] PULSE_COUNT_MAX        = 5'h1f;

    // second state word
    localparam int THERMAL_DISABLE_BIT   = 15;
    localparam int CLOCKLOSS_DISABLE_BIT = 14;
    localparam int OPEN_DETECT_EN_BIT    = 13;
    localparam int SHORT_DETECT_EN_BIT   = 12;
    localparam int ASYNC_BIT             = 11;
    localparam int DIVIDED_PWM_BIT       = 10;
    localparam int STANDBY2_BIT          = 9;
    localparam int SHORT_LEVEL_BIT       = 8;
    localparam int DELAY_DISABLE_BIT     = 7;
    localparam int SERIAL_OUT_EDGE_BIT         = 6;
    localparam int ONESHOT_BIT           = 5;
    localparam logic [15:0] STATE_WORD_TWO_RESET = 16'h0000;

    // first state word
    localparam int RESOLUTION_MSB = 15;
    localparam int RESOLUTION_LSB = 14;
    localparam int INIT_BIT       = 13;
    localparam int STANDBY1_BIT   = 12;

    localparam logic [1:0] RES_16BIT = 2'h0;
    localparam logic [1:0] RES_14BIT = 2'h1;
    localparam logic [1:0] RES_12BIT = 2'h2;
    localparam logic [1:0] RES_10BIT = 2'h3;
    localparam logic [16:0] STEPS_16BIT = 17'h1_0000;
    localparam logic [16:0] STEPS_14BIT = 17'h0_4000;
    localparam logic [16:0] STEPS_12BIT = 17'h0_1000;
    localparam logic [16:0] STEPS_10BIT = 17'h0_0400;

    // timing
    localparam int CLOCK_HZ         = 10_000_000;
    localparam int GRAY_LOSS_MS     = 1000;
    localparam int GRAY_LOSS_CYCLES = CLOCK_HZ / 1000 * GRAY_LOSS_MS;
    localparam int RECOVERY_US      = 30;
    localparam int RECOVERY_CYCLES  = (CLOCK_HZ / 1_000_000) * RECOVERY_US;
    localparam int RECOVERY_W       = 9;
endpackage

// [host_link_model.sv]
/* Host side of the serial link: shifts word bits 15 to 5 MSB first, zeros in place of bits 4 to 0, and frames the
   last pulses in a latch strobe window. Assumes req/ack from the bench. */
`timescale 1ns/100ps
`default_nettype none
module host_link_model (
    input  wire logic        req,
    input  wire logic [15:0] word,
    input  wire logic [4:0]  pulses,
    output logic             ack,
    output logic             shiftClock,
    output logic             serialIn,
    output logic             latchStrobe
);
    int idx;
    int n;

    initial begin
        ack = 1'b0;
        shiftClock = 1'b0;
        serialIn = 1'b0;
        latchStrobe = 1'b0;
        forever begin
            wait (req === 1'b1);
            // odd offset keeps every link edge clear of system clock edges
            #37;
            n = (pulses > 5'h10) ? int'(pulses) : 16;
            for (int i = 0; i < n; i++) begin
                idx = n - 1 - i;
                serialIn = (idx < 16 && idx > 4) ? word[idx] : 1'b0;
                latchStrobe = (i >= n - int'(pulses));
                #80 shiftClock = 1'b1;
                #80 shiftClock = 1'b0;
            end
            #40 latchStrobe = 1'b0;
            // released data line must not keep showing the last bit
            serialIn = !serialIn;
            #600 ack = 1'b1;
            wait (req === 1'b0);
            ack = 1'b0;
        end
    end
endmodule
`default_nettype wire

// [led_driver_state_config_bench.sv]
/* Self-checking bench for the LED driver state configuration block.
   Assumes host_link_model frames every command on the serial link. */
`timescale 1ns/100ps
`default_nettype none
module led_driver_state_config_bench;
    localparam logic [23:0] LOSS = 24'h00_00c8;
    logic        clock = 1'b0, resetn = 1'b0, grayscaleClock = 1'b0, pwmPeriodDone = 1'b0;
    logic        req = 1'b0, ack, shiftClock, serialIn, latchStrobe, serialOut;
    logic        thermalProtectEn, clockLossDetectEn, openDetectEn, shortDetectEn;
    logic        asyncMode, dividedPwm, standby2Active, shortLevelSecond, outputDelayEn;
    logic        serialOutFalling, oneShotMode, internalInit, analogPowerDown;
    logic        outputsReady, outputsForcedOff, pwmRun, pwmRestart, pwmLoadNow;
    logic [1:0]  pwmResolution;
    logic [16:0] pwmMaxCount;
    logic [15:0] word = 16'h0000;
    logic [4:0]  pulses = 5'h00;
    int          failures = 0, total_checks = 0, cycles = 0;
    int          initCnt = 0, restartCnt = 0, loadCnt = 0, readyWait = 0;

    led_driver_state_config #(.GRAY_LOSS_CYCLES(LOSS)) i_led_driver_state_config (
        .clock(clock), .resetn(resetn), .shiftClock(shiftClock), .serialIn(serialIn),
        .latchStrobe(latchStrobe), .grayscaleClock(grayscaleClock),
        .pwmPeriodDone(pwmPeriodDone), .serialOut(serialOut),
        .thermalProtectEn(thermalProtectEn), .clockLossDetectEn(clockLossDetectEn),
        .openDetectEn(openDetectEn), .shortDetectEn(shortDetectEn), .asyncMode(asyncMode),
        .dividedPwm(dividedPwm), .standby2Active(standby2Active),
        .shortLevelSecond(shortLevelSecond), .outputDelayEn(outputDelayEn),
        .serialOutFalling(serialOutFalling), .oneShotMode(oneShotMode),
        .pwmResolution(pwmResolution), .pwmMaxCount(pwmMaxCount),
        .internalInit(internalInit), .analogPowerDown(analogPowerDown),
        .outputsReady(outputsReady), .outputsForcedOff(outputsForcedOff), .pwmRun(pwmRun),
        .pwmRestart(pwmRestart), .pwmLoadNow(pwmLoadNow));

    host_link_model i_host_link_model (
        .req(req), .word(word), .pulses(pulses), .ack(ack), .shiftClock(shiftClock),
        .serialIn(serialIn), .latchStrobe(latchStrobe));

    always #50 clock = ~clock;

    task automatic finish_test();
        if (failures == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // pulse counters and recovery length, sampled like the design does
    always @(posedge clock) begin
        cycles <= cycles + 1;
        initCnt <= initCnt + int'(internalInit === 1'b1);
        restartCnt <= restartCnt + int'(pwmRestart === 1'b1);
        loadCnt <= loadCnt + int'(pwmLoadNow === 1'b1);
        if (analogPowerDown !== 1'b0) begin
            readyWait <= 0;
        end else if (outputsReady === 1'b0) begin
            readyWait <= readyWait + 1;
        end
        if (cycles == 20000) begin
            failures = failures + 1;
            finish_test();
        end
    end

    task automatic check(input string name, input logic [16:0] exp, input logic [16:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic send(input logic [15:0] w, input logic [4:0] p);
        int k;
        @(posedge clock);
        word <= w;
        pulses <= p;
        req <= 1'b1;
        k = 0;
        while (ack !== 1'b1 && k < 200) begin
            @(posedge clock);
            k++;
        end
        check("linkAck", 17'h1, 17'(ack));
        req <= 1'b0;
        repeat (6) @(negedge clock);
    endtask

    task automatic checkWord(input logic [15:0] w, input logic [1:0] r);
        check("decoded", {6'h00, !w[15], !w[14], w[13], w[12], w[11], w[10],
            w[9] && r == 2'h0, w[8], !w[7], w[6], w[5]},
            {6'h00, thermalProtectEn, clockLossDetectEn, openDetectEn, shortDetectEn,
            asyncMode, dividedPwm, standby2Active, shortLevelSecond, outputDelayEn,
            serialOutFalling, oneShotMode});
        check("resolution", 17'(r), 17'(pwmResolution));
        check("maxCount", 17'(17'h1_0000 >> (2 * r)), pwmMaxCount);
    endtask

    task automatic periodEnd();
        @(posedge clock);
        pwmPeriodDone <= 1'b1;
        @(posedge clock);
        pwmPeriodDone <= 1'b0;
        repeat (3) @(negedge clock);
    endtask

    task automatic grayToggle(input int wait_cycles);
        @(posedge clock);
        grayscaleClock <= ~grayscaleClock;
        repeat (wait_cycles) @(negedge clock);
    endtask

    initial begin
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(negedge clock);
        checkWord(16'h0000, 2'h0);
        check("status", 17'h8, 17'({outputsReady, outputsForcedOff, pwmRun, analogPowerDown}));
        for (int b = 5; b < 16; b++) begin
            send(16'(1 << b), 5'h10);
            checkWord(16'(1 << b), 2'h0);
            check("serialOut", 17'(b == 15), 17'(serialOut));
        end
        send(16'ha5e0, 5'h0f);
        checkWord(16'ha5e0, 2'h0);
        send(16'h5a00, 5'h0e);
        send(16'h5a00, 5'h11);
        checkWord(16'ha5e0, 2'h0);
        send(16'h0200, 5'h10);
        for (int r = 0; r < 4; r++) begin
            send({2'(r), 14'h0000}, 5'h05);
            checkWord(16'h0200, 2'(r));
        end
        send(16'h2000, 5'h05);
        check("initPulses", 17'h1, 17'(initCnt));
        checkWord(16'h0000, 2'h0);
        send(16'h3000, 5'h10);
        send(16'h1000, 5'h05);
        check("standby", 17'h2, 17'({analogPowerDown, outputsReady}));
        checkWord(16'h3000, 2'h0);
        send(16'h0000, 5'h01);
        check("exit", 17'h0, 17'({analogPowerDown, outputsReady}));
        repeat (320) @(negedge clock);
        check("recovery", 17'h3, 17'({outputsReady, readyWait >= 296 && readyWait <= 304}));
        grayToggle(150);
        check("forcedOff", 17'h0, 17'(outputsForcedOff));
        repeat (100) @(negedge clock);
        check("forcedOff", 17'h1, 17'(outputsForcedOff));
        grayToggle(5);
        check("forcedOff", 17'h0, 17'(outputsForcedOff));
        repeat (250) @(negedge clock);
        send(16'h2000, 5'h05);
        check("forcedOff", 17'h0, 17'(outputsForcedOff));
        send(16'h4000, 5'h10);
        grayToggle(250);
        check("forcedOff", 17'h0, 17'(outputsForcedOff));
        send(16'h2000, 5'h05);
        send(16'h0000, 5'h03);
        check("sync", 17'h3, 17'({pwmRun, restartCnt == 1}));
        send(16'h0000, 5'h03);
        check("pending", 17'h1, 17'(restartCnt + loadCnt));
        periodEnd();
        check("loadNow", 17'h1, 17'(loadCnt));
        send(16'h0800, 5'h10);
        send(16'h0000, 5'h03);
        check("async", 17'h2, 17'(restartCnt));
        send(16'h0020, 5'h10);
        periodEnd();
        check("oneShot", 17'h0, 17'(pwmRun));
        send(16'h0000, 5'h10);
        send(16'h0000, 5'h03);
        periodEnd();
        check("repeat", 17'h1, 17'(pwmRun));
        send(16'h2000, 5'h05);
        check("stopped", 17'h0, 17'(pwmRun));
        finish_test();
    end
endmodule
`default_nettype wire
